// ==== vlcr_pkg.sv ====
// Shared constants for the link configuration register block
package vlcr_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Link widths
    localparam int unsigned ADDR_W = 24;                  // Window offset width
    localparam int unsigned DATA_W = 32;                  // Data width

    ////////////////////////////////////////////////////////////////////////
    // Device register offsets within the inward window
    localparam logic [23:0] OFS_DMA_SID      = 24'h000020; // Dma status/id register
    localparam logic [23:0] OFS_MOD_CTRL_TWO = 24'h000758; // module_control_two
    localparam logic [23:0] OFS_SHARED_LINK  = 24'h000c40; // shared_link_control
    localparam logic [23:0] OFS_REG_TOP      = 24'h000fff; // Last register-space offset

    ////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int unsigned BIT_CFG_EN     = 7;           // config_space_enable
    localparam int unsigned BIT_CTRL2_BS   = 29;          // dma_ctrl2_burst_select
    localparam int unsigned BIT_CTRL1_BS   = 28;          // dma_ctrl1_burst_select
    localparam int unsigned BIT_QUALIFIER  = 27;          // burst_set_clear_qualifier
    localparam int unsigned SID_HI_LSB     = 3;           // Writable status/id bits 7:3
    localparam int unsigned SID_HI_MSB     = 7;

    ////////////////////////////////////////////////////////////////////////
    // Fixed read and write patterns
    localparam logic [2:0]  SID_LO_IACK    = 3'b011;      // Low status/id bits in iack
    localparam logic [2:0]  SID_LO_DIRECT  = 3'b000;      // Low bits on direct read
    localparam logic [31:0] MCT_READ_FIXED = 32'h00000001; // Constant bits of module_control_two
    localparam logic [31:0] MCT_WRITE_KEEP = 32'h00000080; // Bits software may vary
    localparam logic [31:0] MCT_WRITE_ONE  = 32'h00000001; // Bit always written as one
    localparam logic [31:0] SLC_READ_FIXED = 32'h00c10100; // Constant bits of shared_link_control
    localparam logic [31:0] SLC_WRITE_KEEP = 32'h3fffffff; // Reserved top bits written as zero

    ////////////////////////////////////////////////////////////////////////
    // Host APB register map
    localparam logic [7:0]  APB_CMD        = 8'h00;       // Start command
    localparam logic [7:0]  APB_ADDR       = 8'h04;       // Link offset
    localparam logic [7:0]  APB_WDATA      = 8'h08;       // Link write data
    localparam logic [7:0]  APB_RDATA      = 8'h0c;       // Last answer data
    localparam logic [7:0]  APB_STATUS     = 8'h10;       // Busy and window state
    localparam int unsigned CMD_BIT_WE     = 0;           // Command: write
    localparam int unsigned CMD_BIT_IACK   = 1;           // Command: iack cycle
    localparam int unsigned CMD_BIT_GO     = 2;           // Command: start

    ////////////////////////////////////////////////////////////////////////
    // State encodings
    typedef enum logic [1:0] {
        DEV_IDLE = 2'b00,
        DEV_MEM  = 2'b01,
        DEV_DONE = 2'b11
    } vlcr_dev_state_type;

    typedef enum logic [1:0] {
        HST_IDLE = 2'b00,
        HST_REQ  = 2'b01,
        HST_WAIT = 2'b11
    } vlcr_hst_state_type;

endpackage

// ==== vlcr_link_if.sv ====
`timescale 1ns/1ps
// Register link between the bus master and the device
interface vlcr_link_if;
    logic        req;      // Request held until ack
    logic        we;       // Write when high
    logic        iack;     // Interrupt acknowledge cycle
    logic [23:0] addr;     // Window offset
    logic [31:0] wdata;    // Write data
    logic        ack;      // One-cycle answer
    logic [31:0] rdata;    // Read or status/id data

    // Device end
    modport dev  (input req, we, iack, addr, wdata, output ack, rdata);
    // Master end
    modport host (output req, we, iack, addr, wdata, input ack, rdata);
endinterface

// ==== vlcr_device.sv ====
// Contract
// [R1] 16-bit status/id: low bits give id 10:8
// [R2] 8-bit status/id, no substitution: bits 2:0
// [R3] Low bits 011 in iack, 000 direct
// [R4] Enable set: offsets above FFF reach EEPROM
// [R5] Master sets enable before EEPROM access
// [R6] Master clears enable after configuration work
// [R7] Master alone uses high offsets while enabled
// [R8] Hard reset clears enable; soft keeps it
// [R9] Control two written: zeros, bit0 one
// [R10] Select and qualifier one: burst cycles
// [R11] Select one, qualifier zero: normal cycles
// [R12] Select written zero leaves state alone
// [R13] Select reads back burst state
// [R14] Selection affects block cycles only
// [R15] Shared control bits 31-30 written zero
// [R16] Byte mode with substitution: logical address only
// [R17] Low offsets always reach register space
`timescale 1ns/1ps
module vlcr_device
    import vlcr_pkg::*;
(
    // Clock and hard reset
    input  wire logic                     core_clk,
    input  wire logic                     rstn,
    // Link from the master
    vlcr_link_if.dev                      link,
    // Interrupt configuration inputs
    input  wire logic                     status_id_byte_mode,
    input  wire logic                     status_id_logical_address_select,
    input  wire logic [7:0]               logical_address,
    // Onboard memory port
    output logic                          mem_req_q,
    output logic                          mem_eeprom_q,
    output logic                          mem_we_q,
    output logic [vlcr_pkg::ADDR_W-1:0]   mem_addr_q,
    output logic [vlcr_pkg::DATA_W-1:0]   mem_wdata_q,
    input  wire logic                     mem_ack,
    input  wire logic [vlcr_pkg::DATA_W-1:0] mem_rdata,
    // Controller cycle requests to the extension bus
    input  wire logic                     dma2_cyc_req,
    input  wire logic                     dma2_cyc_block,
    output logic                          dma2_cyc_go_q,
    output logic                          dma2_cyc_sync_burst_q,
    // Mode outputs
    output logic                          config_space_enable_q,
    output logic                          dma_ctrl2_burst_select_q,
    output logic                          dma_ctrl1_burst_select_q
);
    import vlcr_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    vlcr_dev_state_type state_q;           // Link answer state
    vlcr_dev_state_type state_d;           // Next link state
    logic        ack_q;                    // Answer pulse
    logic [31:0] rdata_q;                  // Answer data
    logic [4:0]  sid_hi_q;                 // Status/id bits 7:3
    logic [4:0]  sid_hi_d;
    logic        cfg_en_d;                 // Next config enable
    logic        bs2_d;                    // Next controller-2 select
    logic        bs1_d;                    // Next controller-1 select

    ////////////////////////////////////////////////////////////////////////
    // Request decode
    wire         take      = (state_q == DEV_IDLE) && link.req;          // New request
    wire         high_ofs  = link.addr > OFS_REG_TOP;                    // Above register space
    wire         mem_path  = take && !link.iack && high_ofs;             // To DRAM or EEPROM
    wire         reg_path  = take && !link.iack && !high_ofs;            // Register access
    wire         reg_wr    = reg_path && link.we;                        // Register write
    wire         wr_sid    = reg_wr && (link.addr == OFS_DMA_SID);
    wire         wr_mct    = reg_wr && (link.addr == OFS_MOD_CTRL_TWO);
    wire         wr_slc    = reg_wr && (link.addr == OFS_SHARED_LINK);

    ////////////////////////////////////////////////////////////////////////
    // Register next values
    assign cfg_en_d = wr_mct ? link.wdata[BIT_CFG_EN] : config_space_enable_q;
    assign sid_hi_d = wr_sid ? link.wdata[SID_HI_MSB:SID_HI_LSB] : sid_hi_q;
    // Select bit written one loads the qualifier, zero keeps the state
    assign bs2_d    = (wr_slc && link.wdata[BIT_CTRL2_BS]) ?                // R12
                      link.wdata[BIT_QUALIFIER] : dma_ctrl2_burst_select_q; // R10 R11
    assign bs1_d    = (wr_slc && link.wdata[BIT_CTRL1_BS]) ?
                      link.wdata[BIT_QUALIFIER] : dma_ctrl1_burst_select_q;

    ////////////////////////////////////////////////////////////////////////
    // Direct read values
    wire [31:0] rd_sid = {24'h000000, sid_hi_q, SID_LO_DIRECT};          // R3
    wire [31:0] rd_mct = MCT_READ_FIXED | ({31'h00000000, config_space_enable_q} << BIT_CFG_EN);
    wire [31:0] rd_slc = SLC_READ_FIXED
                       | ({31'h00000000, dma_ctrl2_burst_select_q} << BIT_CTRL2_BS)  // R13
                       | ({31'h00000000, dma_ctrl1_burst_select_q} << BIT_CTRL1_BS);
    // Unmapped register offsets read as zero
    wire [31:0] rd_reg = (link.addr == OFS_DMA_SID)      ? rd_sid :
                         (link.addr == OFS_MOD_CTRL_TWO) ? rd_mct :
                         (link.addr == OFS_SHARED_LINK)  ? rd_slc : 32'h00000000;  // R17

    ////////////////////////////////////////////////////////////////////////
    // Status/id presented in interrupt acknowledge
    wire [7:0]  sid_byte = {sid_hi_q, SID_LO_IACK};                      // R3
    wire [15:0] sid_16   = {sid_byte, logical_address};                  // R1
    wire [15:0] sid_8    = {8'h00, sid_byte};                            // R2
    wire [15:0] sid_la   = {8'h00, logical_address};                     // R16
    wire [15:0] sid_sel  = !status_id_byte_mode                 ? sid_16 :  // R1
                           !status_id_logical_address_select    ? sid_8  :  // R2
                                                                  sid_la;   // R16

    ////////////////////////////////////////////////////////////////////////
    // Link state sequencing
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            DEV_IDLE: if (mem_path) state_d = DEV_MEM;       // Wait on memory
                      else if (take) state_d = DEV_DONE;     // Register or iack
            DEV_MEM:  if (mem_ack) state_d = DEV_DONE;       // Memory answered
            DEV_DONE: state_d = DEV_IDLE;                    // Let the request drop
            default:  state_d = DEV_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // State and answer registers
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_q <= DEV_IDLE;
            ack_q   <= 1'b0;
            rdata_q <= 32'h00000000;
        end
        else
        begin
            state_q <= state_d;
            ack_q   <= (take && !mem_path) || (state_q == DEV_MEM && mem_ack);
            if (take && link.iack)
                rdata_q <= {16'h0000, sid_sel};
            else if (reg_path)
                rdata_q <= link.we ? 32'h00000000 : rd_reg;
            else if (state_q == DEV_MEM && mem_ack)
                rdata_q <= link.we ? 32'h00000000 : mem_rdata;
        end
    end

    assign link.ack   = ack_q;
    assign link.rdata = rdata_q;

    ////////////////////////////////////////////////////////////////////////
    // Configuration registers, cleared by hard reset only
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            config_space_enable_q    <= 1'b0;                  // R8
            sid_hi_q                 <= 5'h00;
            dma_ctrl2_burst_select_q <= 1'b0;
            dma_ctrl1_burst_select_q <= 1'b0;
        end
        else
        begin
            config_space_enable_q    <= cfg_en_d;
            sid_hi_q                 <= sid_hi_d;
            dma_ctrl2_burst_select_q <= bs2_d;
            dma_ctrl1_burst_select_q <= bs1_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Onboard memory request, routed by the config enable
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            mem_req_q    <= 1'b0;
            mem_eeprom_q <= 1'b0;
            mem_we_q     <= 1'b0;
            mem_addr_q   <= 24'h000000;
            mem_wdata_q  <= 32'h00000000;
        end
        else if (mem_path)
        begin
            mem_req_q    <= 1'b1;
            mem_eeprom_q <= config_space_enable_q;            // R4
            mem_we_q     <= link.we;
            mem_addr_q   <= link.addr;
            mem_wdata_q  <= link.wdata;
        end
        else if (mem_ack)
        begin
            mem_req_q    <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Extension-bus cycle type for controller 2
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            dma2_cyc_go_q         <= 1'b0;
            dma2_cyc_sync_burst_q <= 1'b0;
        end
        else
        begin
            dma2_cyc_go_q         <= dma2_cyc_req;
            // Single cycles never become burst cycles
            dma2_cyc_sync_burst_q <= dma2_cyc_req && dma2_cyc_block
                                     && dma_ctrl2_burst_select_q;  // R14
        end
    end

endmodule

// ==== vlcr_master.sv ====
`timescale 1ns/1ps
module vlcr_master
    import vlcr_pkg::*;
(
    // Clock and reset
    input  wire logic          core_clk,
    input  wire logic          rstn,
    // APB slave
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [7:0]    paddr,
    input  wire logic [31:0]   pwdata,
    output logic [31:0]        prdata_q,
    output logic               pready_q,
    // Link to the device
    vlcr_link_if.host          link
);
    import vlcr_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    vlcr_hst_state_type state_q;           // Transfer state
    logic        req_q;                    // Link request
    logic        we_q;                     // Link direction
    logic        iack_q;                   // Link iack
    logic [23:0] addr_q;                   // Offset register
    logic [31:0] wdata_q;                  // Write data register
    logic [31:0] rdata_q;                  // Last answer
    logic        cfg_open_q;               // Config window believed open

    ////////////////////////////////////////////////////////////////////////
    // APB decode
    wire        apb_do  = psel && penable && pready_q;        // Access completes
    wire        apb_wr  = apb_do && pwrite;
    wire        busy    = state_q != HST_IDLE;
    wire        go      = apb_wr && (paddr == APB_CMD) && pwdata[CMD_BIT_GO] && !busy;
    // Outgoing data with the reserved fields forced
    wire [31:0] mct_out = (wdata_q & MCT_WRITE_KEEP) | MCT_WRITE_ONE;  // R9
    wire [31:0] slc_out = wdata_q & SLC_WRITE_KEEP;                    // R15
    wire [31:0] out_dat = (addr_q == OFS_MOD_CTRL_TWO) ? mct_out :
                          (addr_q == OFS_SHARED_LINK)  ? slc_out : wdata_q;
    wire [31:0] rd_mux  = (paddr == APB_ADDR)   ? {8'h00, addr_q} :
                          (paddr == APB_WDATA)  ? wdata_q :
                          (paddr == APB_RDATA)  ? rdata_q :
                          (paddr == APB_STATUS) ? {30'h00000000, cfg_open_q, busy} : 32'h00000000;

    ////////////////////////////////////////////////////////////////////////
    // APB answer, one wait cycle
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pready_q <= 1'b0;
            prdata_q <= 32'h00000000;
        end
        else
        begin
            pready_q <= psel && penable && !pready_q;
            prdata_q <= rd_mux;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Order registers
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            addr_q  <= 24'h000000;
            wdata_q <= 32'h00000000;
        end
        else if (!busy)
        begin
            if (apb_wr && paddr == APB_ADDR)
                addr_q  <= pwdata[23:0];
            if (apb_wr && paddr == APB_WDATA)
                wdata_q <= pwdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Link transfer, request held until the device answers
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_q    <= HST_IDLE;
            req_q      <= 1'b0;
            we_q       <= 1'b0;
            iack_q     <= 1'b0;
            rdata_q    <= 32'h00000000;
            cfg_open_q <= 1'b0;
        end
        else
        begin
            unique case (state_q)
                HST_IDLE:
                    if (go)
                    begin
                        req_q   <= 1'b1;
                        we_q    <= pwdata[CMD_BIT_WE];
                        iack_q  <= pwdata[CMD_BIT_IACK];
                        state_q <= HST_REQ;
                    end
                HST_REQ:
                    state_q <= HST_WAIT;
                HST_WAIT:
                    if (link.ack)
                    begin
                        req_q   <= 1'b0;
                        rdata_q <= link.rdata;
                        state_q <= HST_IDLE;
                        // Track the enable so software sees it must close it
                        if (we_q && !iack_q && addr_q == OFS_MOD_CTRL_TWO)
                            cfg_open_q <= mct_out[BIT_CFG_EN];  // R5 R6 R7
                    end
                default:
                    state_q <= HST_IDLE;
            endcase
        end
    end

    assign link.req   = req_q;
    assign link.we    = we_q;
    assign link.iack  = iack_q;
    assign link.addr  = addr_q;
    assign link.wdata = out_dat;

endmodule

// ==== vlcr_link_properties.sv ====
`timescale 1ns/1ps
// Link protocol and register read- and write-format checks
module vlcr_link_properties
(
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        rstn,
    // Link signals
    input wire logic        req,
    input wire logic        we,
    input wire logic        iack,
    input wire logic [23:0] addr,
    input wire logic [31:0] wdata,
    input wire logic        ack,
    input wire logic [31:0] rdata
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    ////////////////////////////////////////////////////////////////////////
    // Handshake
    a_ack_one_cycle: assert property (ack |=> !ack) else $error("ack longer than one cycle");
    a_ack_needs_req: assert property (ack |-> req) else $error("ack without request");
    a_req_release: assert property (ack |=> !req) else $error("request held after ack");
    a_req_holds: assert property (req && !ack |=> req && $stable(addr) && $stable(we) && $stable(wdata)
        && $stable(iack)) else $error("request changed before ack");
    a_reg_answer: assert property ($rose(req) && (iack || addr <= 24'h000fff) |=> ack)
        else $error("register answer late");
    a_mem_answer: assert property ($rose(req) && !iack && addr > 24'h000fff |=> !ack ##[1:20] ack)
        else $error("memory answer out of range");

    ////////////////////////////////////////////////////////////////////////
    // Register formats
    a_sid_direct: assert property (ack && !we && !iack && addr == 24'h000020 |-> rdata[2:0] == 3'b000)
        else $error("direct status id low bits wrong");
    a_mct_read: assert property (ack && !we && !iack && addr == 24'h000758 |->
        (rdata & 32'hffffff7f) == 32'h00000001) else $error("control two read format wrong");
    a_slc_read: assert property (ack && !we && !iack && addr == 24'h000c40 |->
        (rdata & 32'hcfffffff) == 32'h00c10100) else $error("shared control read format wrong");
    a_mct_write: assert property (req && we && !iack && addr == 24'h000758 |->
        (wdata & 32'hffffff7f) == 32'h00000001) else $error("control two write data wrong");
    a_slc_write: assert property (req && we && !iack && addr == 24'h000c40 |-> wdata[31:30] == 2'b00)
        else $error("shared control reserved bits written");
    a_write_answer: assert property (ack && we && addr <= 24'h000fff |-> rdata == 32'h00000000)
        else $error("write answer data not zero");
endmodule

// ==== vme_link_config_registers_tb.sv ====
`timescale 1ns/1ps
module vme_link_config_registers_tb;
    import vlcr_pkg::*;
    // Bench drive and observation
    logic        core_clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, mem_ack = 0;
    logic        bmode = 0, lasel = 0, dreq = 0, dblk = 0, meep = 0;
    logic [7:0]  paddr = 8'h00, la = 8'h00;
    logic [31:0] pwdata = 32'h0, mem_rdata = 32'h0, prdata_q, mdat, rd, r, mwd;
    logic [23:0] mem_addr_q, maddr;
    logic        pready_q, mem_req_q, mem_eeprom_q, mem_we_q, go_q, sb_q, cfg_q, sel2_q, sel1_q;
    int          n_mismatch = 0, checks_done = 0, mwait = 0;
    // Behavioural register model
    int          sid = 0, cfg = 0, s2 = 0, s1 = 0;
    logic [31:0] tab [4] = '{32'h28000000, 32'h08000000, 32'h20000000, 32'hc0000000};

    vlcr_link_if lnk();
    vlcr_master vlcr_master_i (.core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q), .pready_q(pready_q), .link(lnk));
    vlcr_device vlcr_device_i (.core_clk(core_clk), .rstn(rstn), .link(lnk), .status_id_byte_mode(bmode),
        .status_id_logical_address_select(lasel), .logical_address(la), .mem_req_q(mem_req_q),
        .mem_eeprom_q(mem_eeprom_q), .mem_we_q(mem_we_q), .mem_addr_q(mem_addr_q), .mem_wdata_q(mwd),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata), .dma2_cyc_req(dreq), .dma2_cyc_block(dblk),
        .dma2_cyc_go_q(go_q), .dma2_cyc_sync_burst_q(sb_q), .config_space_enable_q(cfg_q),
        .dma_ctrl2_burst_select_q(sel2_q), .dma_ctrl1_burst_select_q(sel1_q));
    vlcr_link_properties vlcr_link_properties_i (.core_clk(core_clk), .rstn(rstn), .req(lnk.req), .we(lnk.we),
        .iack(lnk.iack), .addr(lnk.addr), .wdata(lnk.wdata), .ack(lnk.ack), .rdata(lnk.rdata));

    // Clock
    always #20 core_clk = ~core_clk;

    ////////////////////////////////////////////////////////////////////////
    // Memory responder, data changes every cycle
    always @(posedge core_clk)
    begin
        r = $urandom;
        mem_rdata <= r;
        mem_ack   <= 1'b0;
        if (mem_req_q === 1'b1 && !mem_ack)
        begin
            if (mwait == 0)
            begin
                mem_ack <= 1'b1;
                mdat    <= r;
                maddr   <= mem_addr_q;
                meep    <= mem_eeprom_q;
                mwait   <= $urandom_range(3, 0);
            end
            else
                mwait <= mwait - 1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Tasks
    task automatic final_report();
        $display("checks_done %0d n_mismatch %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // One APB transfer, waits for pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge core_clk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        // Wait for the slave, a hang is left to the watchdog
        do
            @(posedge core_clk);
        while (pready_q !== 1'b1);
        q = prdata_q;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // One link transfer through the command registers
    task automatic xfer(input logic w, input logic ik, input logic [23:0] a, input logic [31:0] d);
        apb(1'b1, APB_ADDR, {8'h00, a}, rd);
        apb(1'b1, APB_WDATA, d, rd);
        apb(1'b1, APB_CMD, {29'h0, 1'b1, ik, w}, rd);
        do
            apb(1'b0, APB_STATUS, 32'h0, rd);
        while (rd[0] !== 1'b0);
        apb(1'b0, APB_RDATA, 32'h0, rd);
    endtask

    function automatic logic [31:0] exp_rd(input logic [23:0] a);
        case (a)
            OFS_DMA_SID:      return {24'h0, sid[4:0], 3'b000};
            OFS_MOD_CTRL_TWO: return {24'h0, cfg[0], 7'h01};
            OFS_SHARED_LINK:  return {2'b00, s2[0], s1[0], 28'h0} | 32'h00c10100;
            default:          return 32'h0;
        endcase
    endfunction

    task automatic rd_reg(input logic [23:0] a);
        xfer(1'b0, 1'b0, a, 32'h0);
        cmp(rd, exp_rd(a));
    endtask

    // Register write, model update, mode outputs compared
    task automatic wr_reg(input logic [23:0] a, input logic [31:0] d);
        xfer(1'b1, 1'b0, a, d);
        if (a == OFS_DMA_SID) sid = d[7:3];
        if (a == OFS_MOD_CTRL_TWO) cfg = d[7];
        if (a == OFS_SHARED_LINK && d[29]) s2 = d[27];
        if (a == OFS_SHARED_LINK && d[28]) s1 = d[27];
        cmp({31'h0, cfg_q}, cfg);
        cmp({31'h0, sel2_q}, s2);
        cmp({31'h0, sel1_q}, s1);
    endtask

    // Controller-2 cycle outputs against the burst select
    task automatic dma_chk();
        logic q, b;
        repeat (4)
        begin
            q = $urandom;
            b = $urandom;
            @(posedge core_clk);
            dreq <= q;
            dblk <= b;
            @(posedge core_clk);
            #1;
            cmp({31'h0, go_q}, {31'h0, q});
            cmp({31'h0, sb_q}, {31'h0, q & b & s2[0]});
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Watchdog
    initial
    begin
        #1600000;
        n_mismatch++;
        final_report();
    end

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        logic [23:0] a;
        logic        w;
        logic [31:0] d;
        rd = $urandom(32'h55c3c6d7);
        repeat (8) @(posedge core_clk);
        rstn <= 1'b1;
        rd_reg(OFS_MOD_CTRL_TWO);
        rd_reg(OFS_SHARED_LINK);
        // Unmapped register offset
        wr_reg(24'h000100, $urandom);
        rd_reg(24'h000100);
        // Status id direct and all iack modes
        repeat (3)
        begin
            wr_reg(OFS_DMA_SID, $urandom);
            rd_reg(OFS_DMA_SID);
            for (int m = 0; m < 4; m++)
            begin
                @(posedge core_clk);
                la    <= $urandom;
                bmode <= m[1];
                lasel <= m[0];
                xfer(1'b0, 1'b1, 24'h0, 32'h0);
                if (!bmode) cmp(rd, {16'h0, sid[4:0], 3'b011, la});
                else if (!lasel) cmp(rd, {24'h0, sid[4:0], 3'b011});
                else cmp(rd, {24'h0, la});
            end
        end
        // Configuration window redirect
        for (int k = 0; k < 6; k++)
        begin
            wr_reg(OFS_MOD_CTRL_TWO, $urandom);
            apb(1'b0, APB_STATUS, 32'h0, rd);
            cmp({31'h0, rd[1]}, cfg);
            rd_reg(OFS_MOD_CTRL_TWO);
            a = $urandom_range(24'hffffff, 24'h001000);
            w = $urandom;
            d = $urandom;
            xfer(w, 1'b0, a, d);
            cmp({31'h0, meep}, cfg);
            cmp({8'h0, maddr}, {8'h0, a});
            cmp(mwd, d);
            cmp({31'h0, mem_we_q}, {31'h0, w});
            if (!w) cmp(rd, mdat);
        end
        // Burst select set, clear and untouched
        for (int k = 0; k < 14; k++)
        begin
            wr_reg(OFS_SHARED_LINK, (k < 4) ? tab[k] : $urandom);
            rd_reg(OFS_SHARED_LINK);
            dma_chk();
        end
        // Hard reset in mid-run with the enable and both burst selects set
        wr_reg(OFS_MOD_CTRL_TWO, 32'h00000081);
        wr_reg(OFS_SHARED_LINK, 32'h38000000);
        @(posedge core_clk);
        rstn <= 1'b0;
        repeat (2) @(posedge core_clk);
        rstn <= 1'b1;
        sid = 0;
        cfg = 0;
        s2  = 0;
        s1  = 0;
        #1;
        cmp({29'h0, cfg_q, sel2_q, sel1_q}, 32'h0);
        rd_reg(OFS_DMA_SID);
        rd_reg(OFS_SHARED_LINK);
        final_report();
    end
endmodule
